// file: logic/fis_defs.svh
// Offsets, field positions, reset values and command codes of the flag block
// Assumes inclusion by the top module and the bench only
`ifndef FIS_DEFS_SVH
`define FIS_DEFS_SVH
// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define FIS_IDX_INT_STATUS 16'hf241
`define FIS_IDX_LOCK_START 16'hf24c
`define FIS_IDX_LOCK_END 16'hf24d
`define FIS_IDX_IRQ_STS 16'hf250
`define FIS_IDX_IRQ_MSK 16'hf251
`define FIS_IDX_INFO 16'hf252
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FIS_BIT_INT 15
`define FIS_BIT_LOAD 7
`define FIS_BIT_PROG 6
`define FIS_BIT_ERASE 5
`define FIS_BIT_RESET 4
`define FIS_BIT_OTP 6
`define FIS_BIT_OTP1 5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FIS_RST_COLD 16'h8080
`define FIS_RST_WARM 16'h8010
`define FIS_RST_SBA 10'h000
`define FIS_ECC_NONE 2'h0
// ----------------------------------------
// Command codes
// ----------------------------------------
`define FIS_CMD_LD0 16'h0000
`define FIS_CMD_LD1 16'h000e
`define FIS_CMD_LD2 16'h000c
`define FIS_CMD_LD3 16'h000a
`define FIS_CMD_LD4 16'h0013
`define FIS_CMD_PG0 16'h0080
`define FIS_CMD_PG1 16'h001a
`define FIS_CMD_PG2 16'h001b
`define FIS_CMD_ER0 16'h0094
`define FIS_CMD_ER1 16'h0095
`define FIS_CMD_ER2 16'h0030
`define FIS_CMD_RS0 16'h00b0
`define FIS_CMD_RS1 16'h00f0
`define FIS_CMD_RS2 16'h00f3
`define FIS_CMD_IN0 16'h0065
`define FIS_CMD_IN1 16'h0023
`define FIS_CMD_IN2 16'h0071
`define FIS_CMD_IN3 16'h002a
`define FIS_CMD_IN4 16'h0027
`define FIS_CMD_IN5 16'h002c
`endif

// file: logic/fis_pkg.sv
// Types of the flash interrupt flag block
// Assumes fis_defs.svh is on the include path
package fis_pkg;
  // Flag set: load, program, erase, reset in bit order 3..0
  typedef struct packed {
    logic load;
    logic prog;
    logic erase;
    logic rst;
  } fis_flags_t;
  // Whole state of the top module
  typedef struct packed {
    logic int_bit;
    fis_flags_t flag;
    logic [9:0] lock_first_block_number;
    fis_flags_t irq_sts;
    fis_flags_t irq_msk;
    logic rst_lvl;
    logic [1:0] ecc_main;
    logic [1:0] ecc_spare;
    logic [31:0] rdata;
  } fis_state_t;
endpackage : fis_pkg

// file: logic/fis_top.sv
// Interrupt status flags and lock start block address of a flash controller
// Assumes an APB master on CLK_I, and operation events from same-clock logic
//
// Contract
// - Interrupt pin follows master bit; written zero gives inactive level per polarity.
// - Master bit sets when any class flag sets or listed commands complete.
// - Master, load, program, erase clear on zero write, warm or hot reset, auto-mode command.
// - Reset-done flag clears only on zero write or auto-mode command.
// - Load flag sets on load command completion, buffer load or boot done.
// - Program flag sets on completion of program commands.
// - Erase flag sets on completion of erase commands.
// - Reset flag sets on reset command completion or warm or hot reset release.
// - Status reads 8080h after cold reset, 8010h after warm or hot.
// - Master at bit 15, flags at bits 7 to 4, rest zero.
// - Start block register holds block number in bits 9:0, resets zero.
// - End block location is reserved and has no function.
// - Load interrupted by reset reports both ECC fields as no error.
// - OTP lock bits read one when locked, zero when unlocked.
// - ECC field codes: 00 none, 01 correctable, 10 uncorrectable.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "fis_defs.svh"
module fis_top
  import fis_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [17:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [31:0] PRDATA_O,
  // Configuration held elsewhere
  input wire logic IRQ_POL_I,
  input wire logic AUTO_MODE_I,
  // Controller events
  input wire logic CMD_WR_I,
  input wire logic OP_DONE_I,
  input wire logic [15:0] OP_CODE_I,
  input wire logic BUF_LOAD_DONE_I,
  input wire logic BOOT_DONE_I,
  input wire logic WARM_RST_I,
  input wire logic HOT_RST_I,
  // ECC and OTP inputs
  input wire logic ECC_VALID_I,
  input wire logic [1:0] ECC_MAIN_I,
  input wire logic [1:0] ECC_SPARE_I,
  input wire logic OTP_LOCKED_I,
  input wire logic OTP1_LOCKED_I,
  // Outputs
  output logic INT_PIN_O,
  output logic IRQ_O,
  output logic [9:0] LOCK_BLOCK_O,
  output logic [1:0] MAIN_ECC_O,
  output logic [1:0] SPARE_ECC_O
);

  // ----------------------------------------
  // Command classification
  // ----------------------------------------
  function automatic logic is_load(input logic [15:0] c);
    is_load = (c == `FIS_CMD_LD0) || (c == `FIS_CMD_LD1) || (c == `FIS_CMD_LD2) ||
              (c == `FIS_CMD_LD3) || (c == `FIS_CMD_LD4);
  endfunction : is_load

  function automatic logic is_prog(input logic [15:0] c);
    is_prog = (c == `FIS_CMD_PG0) || (c == `FIS_CMD_PG1) || (c == `FIS_CMD_PG2);
  endfunction : is_prog

  function automatic logic is_erase(input logic [15:0] c);
    is_erase = (c == `FIS_CMD_ER0) || (c == `FIS_CMD_ER1) || (c == `FIS_CMD_ER2);
  endfunction : is_erase

  function automatic logic is_rst(input logic [15:0] c);
    is_rst = (c == `FIS_CMD_RS0) || (c == `FIS_CMD_RS1) || (c == `FIS_CMD_RS2);
  endfunction : is_rst

  // Commands that raise only the master bit
  function automatic logic is_int_only(input logic [15:0] c);
    is_int_only = (c == `FIS_CMD_IN0) || (c == `FIS_CMD_IN1) || (c == `FIS_CMD_IN2) ||
                  (c == `FIS_CMD_IN3) || (c == `FIS_CMD_IN4) || (c == `FIS_CMD_IN5);
  endfunction : is_int_only

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  fis_state_t q;
  fis_state_t d;
  logic [15:0] idx;
  logic wr_en;
  logic rd_setup;
  logic hit;
  logic rst_act;
  logic rst_rel;
  logic cmd_clr;
  fis_flags_t set_f;
  fis_flags_t zero_f;
  logic set_int;
  logic [15:0] status_word;
  // Cold reset pattern, split into flag bits in the reset branch
  localparam logic [15:0] cold_word = `FIS_RST_COLD;

  // Word index; the low two address bits select no byte lane
  assign idx = PADDR_I[17:2];
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign hit = (PADDR_I[1:0] == 2'h0) && ((idx == `FIS_IDX_INT_STATUS) ||
               (idx == `FIS_IDX_LOCK_START) || (idx == `FIS_IDX_LOCK_END) ||
               (idx == `FIS_IDX_IRQ_STS) || (idx == `FIS_IDX_IRQ_MSK) ||
               (idx == `FIS_IDX_INFO));

  // Status word assembled from flags; unlisted bits read zero
  always_comb begin
    status_word = 16'h0000;
    status_word[`FIS_BIT_INT] = q.int_bit;
    status_word[`FIS_BIT_LOAD] = q.flag.load;
    status_word[`FIS_BIT_PROG] = q.flag.prog;
    status_word[`FIS_BIT_ERASE] = q.flag.erase;
    status_word[`FIS_BIT_RESET] = q.flag.rst;
  end

  // Event terms: reset level edges, auto-mode clears, class completions
  assign rst_act = WARM_RST_I | HOT_RST_I;
  assign rst_rel = q.rst_lvl & ~rst_act;
  assign cmd_clr = CMD_WR_I & AUTO_MODE_I;
  assign set_f.load = (OP_DONE_I & is_load(OP_CODE_I)) | BUF_LOAD_DONE_I | BOOT_DONE_I;
  assign set_f.prog = OP_DONE_I & is_prog(OP_CODE_I);
  assign set_f.erase = OP_DONE_I & is_erase(OP_CODE_I);
  assign set_f.rst = (OP_DONE_I & is_rst(OP_CODE_I)) | rst_rel;
  assign set_int = (|set_f) | (OP_DONE_I & is_int_only(OP_CODE_I));

  // Zero written to a flag bit of the status word asks to clear it
  always_comb begin
    zero_f = '0;
    if (wr_en && PADDR_I[1:0] == 2'h0 && idx == `FIS_IDX_INT_STATUS) begin
      zero_f.load = ~PWDATA_I[`FIS_BIT_LOAD];
      zero_f.prog = ~PWDATA_I[`FIS_BIT_PROG];
      zero_f.erase = ~PWDATA_I[`FIS_BIT_ERASE];
      zero_f.rst = ~PWDATA_I[`FIS_BIT_RESET];
    end
  end

  // ----------------------------------------
  // Next state; a set in the same cycle as a clear wins
  // ----------------------------------------
  always_comb begin
    d = q;
    d.rst_lvl = rst_act;
    // Resets clear all but the reset flag, which tells software one happened
    d.flag.load = set_f.load | (q.flag.load & ~(zero_f.load | rst_act | cmd_clr));
    d.flag.prog = set_f.prog | (q.flag.prog & ~(zero_f.prog | rst_act | cmd_clr));
    d.flag.erase = set_f.erase | (q.flag.erase & ~(zero_f.erase | rst_act | cmd_clr));
    d.flag.rst = set_f.rst | (q.flag.rst & ~(zero_f.rst | cmd_clr));
    d.int_bit = set_int | (q.int_bit & ~(rst_act | cmd_clr |
                (wr_en && PADDR_I[1:0] == 2'h0 && idx == `FIS_IDX_INT_STATUS &&
                 !PWDATA_I[`FIS_BIT_INT])));
    // Sticky event copies for the bus interrupt, write one to clear
    d.irq_sts = set_f | (q.irq_sts & ~((wr_en && PADDR_I[1:0] == 2'h0 &&
                idx == `FIS_IDX_IRQ_STS) ?
                fis_flags_t'(PWDATA_I[`FIS_BIT_LOAD:`FIS_BIT_RESET]) : fis_flags_t'(4'h0)));
    if (wr_en && PADDR_I[1:0] == 2'h0) begin
      case (idx)
        `FIS_IDX_LOCK_START: d.lock_first_block_number = PWDATA_I[9:0];
        `FIS_IDX_IRQ_MSK: d.irq_msk = fis_flags_t'(PWDATA_I[`FIS_BIT_LOAD:`FIS_BIT_RESET]);
        default: d.lock_first_block_number = q.lock_first_block_number; // End block location takes no write
      endcase
    end
    // ECC result: new command wipes it, a reset mid-load leaves it at no error
    if (rst_act || CMD_WR_I) begin
      d.ecc_main = `FIS_ECC_NONE;
      d.ecc_spare = `FIS_ECC_NONE;
    end else if (ECC_VALID_I) begin
      d.ecc_main = ECC_MAIN_I;
      d.ecc_spare = ECC_SPARE_I;
    end
    // Read data is latched in the setup cycle so the access phase needs no wait
    if (rd_setup) begin
      d.rdata = 32'h0000_0000;
      if (PADDR_I[1:0] == 2'h0) begin
        case (idx)
          `FIS_IDX_INT_STATUS: d.rdata[15:0] = status_word;
          `FIS_IDX_LOCK_START: d.rdata[9:0] = q.lock_first_block_number;
          `FIS_IDX_IRQ_STS: d.rdata[`FIS_BIT_LOAD:`FIS_BIT_RESET] = q.irq_sts;
          `FIS_IDX_IRQ_MSK: d.rdata[`FIS_BIT_LOAD:`FIS_BIT_RESET] = q.irq_msk;
          `FIS_IDX_INFO: begin
            d.rdata[`FIS_BIT_OTP] = OTP_LOCKED_I;
            d.rdata[`FIS_BIT_OTP1] = OTP1_LOCKED_I;
            d.rdata[3:2] = q.ecc_main;
            d.rdata[1:0] = q.ecc_spare;
          end
          default: d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Cold reset loads the cold pattern; warm release later yields 8010h
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      q <= '0;
      q.int_bit <= cold_word[`FIS_BIT_INT];
      q.flag.load <= cold_word[`FIS_BIT_LOAD];
      q.lock_first_block_number <= `FIS_RST_SBA;
      q.ecc_main <= `FIS_ECC_NONE;
      q.ecc_spare <= `FIS_ECC_NONE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Pin follows master bit; inactive level is the inverse of polarity
  assign INT_PIN_O = q.int_bit ? IRQ_POL_I : ~IRQ_POL_I;
  assign IRQ_O = |(q.irq_sts & q.irq_msk);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
  assign PRDATA_O = q.rdata;
  assign LOCK_BLOCK_O = q.lock_first_block_number;
  assign MAIN_ECC_O = q.ecc_main;
  assign SPARE_ECC_O = q.ecc_spare;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  property p_pin_pol;
    !q.int_bit |-> (INT_PIN_O == ~IRQ_POL_I);
  endproperty
  a_pin_pol: assert property (p_pin_pol) else $error("pin not idle");

  property p_int_set;
    (OP_DONE_I && is_int_only(OP_CODE_I)) |=> q.int_bit;
  endproperty
  a_int_set: assert property (p_int_set) else $error("master bit not set");

  property p_auto_clr;
    (cmd_clr && !(|set_f) && !OP_DONE_I) |=> !q.flag.load && !q.flag.prog && !q.int_bit;
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("auto clear failed");

  property p_rst_keep;
    (q.flag.rst && rst_act && !cmd_clr && !zero_f.rst) |=> q.flag.rst;
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("reset flag lost");

  property p_load_set;
    BOOT_DONE_I |=> q.flag.load && q.int_bit;
  endproperty
  a_load_set: assert property (p_load_set) else $error("load flag not set");

  property p_prog_set;
    (OP_DONE_I && OP_CODE_I == `FIS_CMD_PG1) |=> q.flag.prog ##1
      (q.flag.prog || $past(zero_f.prog) || $past(cmd_clr) || $past(rst_act));
  endproperty
  a_prog_set: assert property (p_prog_set) else $error("program flag not set");

  property p_erase_set;
    (OP_DONE_I && OP_CODE_I == `FIS_CMD_ER2) |=> q.flag.erase;
  endproperty
  a_erase_set: assert property (p_erase_set) else $error("erase flag not set");

  property p_warm_word;
    ($fell(rst_act) && !cmd_clr && !(|zero_f)) |=> (status_word ==
      `FIS_RST_WARM || q.flag.load || q.flag.prog || q.flag.erase);
  endproperty
  a_warm_word: assert property (p_warm_word) else $error("warm value wrong");

  property p_rsvd_zero;
    status_word[14:8] == 7'h00 && status_word[3:0] == 4'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_sba_wr;
    (wr_en && PADDR_I[1:0] == 2'h0 && idx == `FIS_IDX_LOCK_START) |=>
      (q.lock_first_block_number == $past(PWDATA_I[9:0]));
  endproperty
  a_sba_wr: assert property (p_sba_wr) else $error("block number not stored");

  property p_ecc_rst;
    rst_act |=> (MAIN_ECC_O == `FIS_ECC_NONE) && (SPARE_ECC_O == `FIS_ECC_NONE);
  endproperty
  a_ecc_rst: assert property (p_ecc_rst) else $error("ecc not cleared");

  property p_pin_act;
    q.int_bit |-> (INT_PIN_O == IRQ_POL_I);
  endproperty
  a_pin_act: assert property (p_pin_act) else $error("pin not active");

  property p_class_int;
    (|set_f) |=> q.int_bit;
  endproperty
  a_class_int: assert property (p_class_int) else $error("master bit missed a flag");

  property p_mst_clr;
    (rst_act && !set_int) |=> !q.int_bit;
  endproperty
  a_mst_clr: assert property (p_mst_clr) else $error("master bit kept in reset");

  property p_erase_clr;
    (q.flag.erase && rst_act && !set_f.erase) |=> !q.flag.erase;
  endproperty
  a_erase_clr: assert property (p_erase_clr) else $error("erase flag kept in reset");

  property p_zero_clr;
    (zero_f.prog && !set_f.prog) |=> !q.flag.prog;
  endproperty
  a_zero_clr: assert property (p_zero_clr) else $error("zero write did not clear");

  property p_buf_set;
    BUF_LOAD_DONE_I |=> q.flag.load;
  endproperty
  a_buf_set: assert property (p_buf_set) else $error("buffer load not flagged");

  property p_rst_set;
    (OP_DONE_I && is_rst(OP_CODE_I)) |=> q.flag.rst && q.int_bit;
  endproperty
  a_rst_set: assert property (p_rst_set) else $error("reset flag not set");

  property p_end_rsvd;
    (wr_en && PADDR_I[1:0] == 2'h0 && idx == `FIS_IDX_LOCK_END) |=> $stable(q.lock_first_block_number);
  endproperty
  a_end_rsvd: assert property (p_end_rsvd) else $error("end block write had effect");

  property p_ecc_cap;
    (ECC_VALID_I && !rst_act && !CMD_WR_I) |=>
      (MAIN_ECC_O == $past(ECC_MAIN_I)) && (SPARE_ECC_O == $past(ECC_SPARE_I));
  endproperty
  a_ecc_cap: assert property (p_ecc_cap) else $error("ecc code not captured");

  property p_otp_read;
    (rd_setup && PADDR_I[1:0] == 2'h0 && idx == `FIS_IDX_INFO) |=>
      (PRDATA_O[`FIS_BIT_OTP] == $past(OTP_LOCKED_I)) &&
      (PRDATA_O[`FIS_BIT_OTP1] == $past(OTP1_LOCKED_I));
  endproperty
  a_otp_read: assert property (p_otp_read) else $error("otp lock bit wrong");

endmodule : fis_top

// file: sim/fis_ctl_model.sv
// Model of the controller side that reports finished operations and resets
// Assumes the bench calls its tasks from one process at a time per strobe
`timescale 1ns/1ps
module fis_ctl_model (
  // Clock
  input wire logic clk_i,
  // Events toward the flag block
  output logic cmd_wr_o,
  output logic op_done_o,
  output logic [15:0] op_code_o,
  output logic buf_done_o,
  output logic boot_done_o,
  output logic warm_rst_o,
  output logic hot_rst_o,
  // ECC results
  output logic ecc_valid_o,
  output logic [1:0] ecc_main_o,
  output logic [1:0] ecc_spare_o
);
  // Idle levels; code and ECC lines carry junk outside strobes, so a stale value cannot pass
  initial begin
    {cmd_wr_o, op_done_o, buf_done_o, boot_done_o, warm_rst_o, hot_rst_o, ecc_valid_o} = '0;
    op_code_o = 16'h5a5a;
    {ecc_main_o, ecc_spare_o} = 4'h9;
  end
  // One-cycle completion report carrying the operation code
  // Erase completion carries no verdict; the host judges it by a verify read
  task op_done(input logic [15:0] code);
    @(posedge clk_i);
    op_done_o <= 1'b1;
    op_code_o <= code;
    @(posedge clk_i);
    op_done_o <= 1'b0;
    op_code_o <= ~code;
  endtask : op_done
  // One-cycle strobe: bit 2 command write, bit 1 buffer load, bit 0 boot done
  task strobe(input logic [2:0] sel);
    @(posedge clk_i);
    {cmd_wr_o, buf_done_o, boot_done_o} <= sel;
    @(posedge clk_i);
    {cmd_wr_o, buf_done_o, boot_done_o} <= 3'h0;
  endtask : strobe
  // ECC capture strobe with the given result codes
  task ecc(input logic [1:0] m, input logic [1:0] s);
    @(posedge clk_i);
    ecc_valid_o <= 1'b1;
    {ecc_main_o, ecc_spare_o} <= {m, s};
    @(posedge clk_i);
    ecc_valid_o <= 1'b0;
    {ecc_main_o, ecc_spare_o} <= ~{m, s};
  endtask : ecc
  // Warm or hot reset level held for n cycles, then released
  task hold_rst(input logic hot, input int n);
    @(posedge clk_i);
    {warm_rst_o, hot_rst_o} <= {~hot, hot};
    repeat (n) @(posedge clk_i);
    {warm_rst_o, hot_rst_o} <= 2'b00;
  endtask : hold_rst
endmodule : fis_ctl_model

// file: sim/flash_irq_status_and_lock_addr_tb.sv
// Self-checking bench of the flag block: APB master, controller model, port checks
// Assumes fis_defs.svh on the include path and a zero-wait APB slave
`timescale 1ns/1ps
`include "fis_defs.svh"
module flash_irq_status_and_lock_addr_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d;
  logic pready, pslverr, e, pol = 1'b1, auto = 1'b0, otp = 1'b1, otp1 = 1'b0;
  logic cmd, opd, bufd, boot, warm, hot, eccv, int_pin, irq;
  logic [15:0] opc;
  logic [1:0] em, es, ecc_m, ecc_s;
  logic [9:0] blk;
  int failures = 0, checks_done = 0, cycles = 0;
  logic [15:0] codes [20] = '{`FIS_CMD_LD0, `FIS_CMD_LD1, `FIS_CMD_LD2, `FIS_CMD_LD3,
    `FIS_CMD_LD4, `FIS_CMD_PG0, `FIS_CMD_PG1, `FIS_CMD_PG2, `FIS_CMD_ER0, `FIS_CMD_ER1,
    `FIS_CMD_ER2, `FIS_CMD_RS0, `FIS_CMD_RS1, `FIS_CMD_RS2, `FIS_CMD_IN0, `FIS_CMD_IN1,
    `FIS_CMD_IN2, `FIS_CMD_IN3, `FIS_CMD_IN4, `FIS_CMD_IN5};
  fis_top u_fis_top (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PRDATA_O(prdata), .IRQ_POL_I(pol), .AUTO_MODE_I(auto),
    .CMD_WR_I(cmd), .OP_DONE_I(opd), .OP_CODE_I(opc), .BUF_LOAD_DONE_I(bufd),
    .BOOT_DONE_I(boot), .WARM_RST_I(warm), .HOT_RST_I(hot), .ECC_VALID_I(eccv),
    .ECC_MAIN_I(em), .ECC_SPARE_I(es), .OTP_LOCKED_I(otp), .OTP1_LOCKED_I(otp1),
    .INT_PIN_O(int_pin), .IRQ_O(irq), .LOCK_BLOCK_O(blk), .MAIN_ECC_O(ecc_m),
    .SPARE_ECC_O(ecc_s));
  fis_ctl_model u_fis_ctl_model (.clk_i(clk), .cmd_wr_o(cmd), .op_done_o(opd),
    .op_code_o(opc), .buf_done_o(bufd), .boot_done_o(boot), .warm_rst_o(warm),
    .hot_rst_o(hot), .ecc_valid_o(eccv), .ecc_main_o(em), .ecc_spare_o(es));
  // ----------------------------------------
  // Clock, timeout, reporting
  // ----------------------------------------
  always #12.5 clk = ~clk;
  // Whole run needs well under 2000 cycles; a hang counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      wrap_up();
    end
  end
  task wrap_up();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // APB transfer: request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, wr, idx, 2'b00, wd};
    @(posedge clk);
    pen <= 1'b1;
    // pready high ends this wait; if it never rises, only the bench timeout ends it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    {psel, pen} <= 2'b00;
  endtask : apb
  task rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, exp, d);
    chk("slave error", 32'h0, {31'h0, e});
  endtask : rd_chk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset();
    rd_chk("status", `FIS_IDX_INT_STATUS, 32'h8080);
    chk("pin", 32'h1, {31'h0, int_pin});
    rd_chk("start block", `FIS_IDX_LOCK_START, 32'h0);
    rd_chk("end block", `FIS_IDX_LOCK_END, 32'h0);
    apb(1'b0, 16'h0001, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("reset test done");
  endtask : t_reset
  task t_clear();
    apb(1'b1, `FIS_IDX_INT_STATUS, 32'h7fff);
    rd_chk("master cleared", `FIS_IDX_INT_STATUS, 32'h0080);
    chk("pin high pol", 32'h0, {31'h0, int_pin});
    pol <= 1'b0;
    @(negedge clk);
    chk("pin low pol", 32'h1, {31'h0, int_pin});
    apb(1'b1, `FIS_IDX_INT_STATUS, 32'hffff_0000);
    rd_chk("all cleared", `FIS_IDX_INT_STATUS, 32'h0);
    $display("clear test done");
  endtask : t_clear
  task t_codes();
    logic [31:0] x;
    for (int i = 0; i < 22; i++) begin
      if (i < 20) u_fis_ctl_model.op_done(codes[i]);
      else u_fis_ctl_model.strobe(i == 20 ? 3'h2 : 3'h1);
      x = i < 5 || i > 19 ? 32'h8080 : i < 8 ? 32'h8040 : i < 11 ? 32'h8020 :
          i < 14 ? 32'h8010 : 32'h8000;
      rd_chk("event flags", `FIS_IDX_INT_STATUS, x);
      chk("pin active low", 32'h0, {31'h0, int_pin});
      apb(1'b1, `FIS_IDX_INT_STATUS, 32'h0);
    end
    $display("event test done");
  endtask : t_codes
  task t_warm();
    for (int h = 0; h < 2; h++) begin
      // Warm pass starts with the reset flag clear, so only the release can raise it
      if (h == 0) apb(1'b1, `FIS_IDX_INT_STATUS, 32'h0);
      u_fis_ctl_model.op_done(`FIS_CMD_PG0);
      if (h == 1) u_fis_ctl_model.op_done(`FIS_CMD_RS0);
      fork
        u_fis_ctl_model.hold_rst(h[0], 8);
        begin
          repeat (2) @(posedge clk);
          rd_chk("during reset", `FIS_IDX_INT_STATUS, h == 1 ? 32'h0010 : 32'h0);
        end
      join
      rd_chk("after reset", `FIS_IDX_INT_STATUS, 32'h8010);
    end
    $display("warm reset test done");
  endtask : t_warm
  task t_auto();
    u_fis_ctl_model.strobe(3'h4);
    rd_chk("manual command", `FIS_IDX_INT_STATUS, 32'h8010);
    auto <= 1'b1;
    u_fis_ctl_model.strobe(3'h4);
    rd_chk("auto command", `FIS_IDX_INT_STATUS, 32'h0);
    auto <= 1'b0;
    $display("auto mode test done");
  endtask : t_auto
  task t_lock();
    apb(1'b1, `FIS_IDX_LOCK_START, 32'hffff_ffff);
    rd_chk("start block max", `FIS_IDX_LOCK_START, 32'h03ff);
    apb(1'b1, `FIS_IDX_LOCK_START, 32'h0155);
    @(negedge clk);
    chk("block out", 32'h155, {22'h0, blk});
    apb(1'b1, `FIS_IDX_LOCK_END, 32'hffff_ffff);
    rd_chk("start after end write", `FIS_IDX_LOCK_START, 32'h0155);
    rd_chk("end block", `FIS_IDX_LOCK_END, 32'h0);
    $display("lock address test done");
  endtask : t_lock
  task t_irq();
    apb(1'b1, `FIS_IDX_IRQ_STS, 32'hf0);
    apb(1'b1, `FIS_IDX_IRQ_MSK, 32'h0);
    u_fis_ctl_model.op_done(`FIS_CMD_ER0);
    rd_chk("irq status", `FIS_IDX_IRQ_STS, 32'h20);
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'b1, `FIS_IDX_IRQ_MSK, 32'h20);
    @(negedge clk);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    apb(1'b1, `FIS_IDX_IRQ_STS, 32'h20);
    @(negedge clk);
    chk("cleared irq", 32'h0, {31'h0, irq});
    $display("interrupt test done");
  endtask : t_irq
  task t_ecc();
    for (int c = 1; c < 3; c++) begin
      u_fis_ctl_model.ecc(c[1:0], 2'(3 - c));
      @(negedge clk);
      chk("ecc codes", c * 4 + 3 - c, {28'h0, ecc_m, ecc_s});
      rd_chk("ecc in info", `FIS_IDX_INFO, 32'h40 | (c * 4 + 3 - c));
      u_fis_ctl_model.hold_rst(1'b1, 2);
      @(negedge clk);
      chk("ecc after reset", 32'h0, {28'h0, ecc_m, ecc_s});
    end
    rd_chk("otp lock bits", `FIS_IDX_INFO, 32'h40);
    {otp, otp1} <= 2'b01;
    rd_chk("first block otp bit", `FIS_IDX_INFO, 32'h20);
    $display("ecc and otp test done");
  endtask : t_ecc
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_clear();
    t_codes();
    t_warm();
    t_auto();
    t_lock();
    t_irq();
    t_ecc();
    wrap_up();
  end
endmodule : flash_irq_status_and_lock_addr_tb
